// *** testbench.sv ***
// Self-checking testbench for the function and interface control block
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic [5:0] waddr;
    logic [7:0] wdata;
    logic [5:0] raddr;
    logic [7:0] exp;
  } ufic_row_t;

  logic clk, rst_n, ulpi_data_oe, ulpi_dir, ulpi_nxt, ulpi_stp, serial_mode_exit;
  logic [7:0] ulpi_data_in, ulpi_data_out, rxcmd_status, v, rd;
  logic dplus_pulldown_enable, dminus_pulldown_enable, core_reset, power_down;
  logic fs_preamble_enable, dplus_pullup, dminus_pullup, hs_termination;
  logic dplus_pulldown, dminus_pulldown, ok, ok2;
  ufic_pkg::ufic_func_t func_ctrl;
  ufic_pkg::ufic_intf_t intf_ctrl;
  ufic_row_t rows [8];
  int n_mismatch = 0;
  int checks = 0;
  int w;

  ufic_ctrl uut (.clk, .rst_n, .ulpi_data_in, .ulpi_data_out, .ulpi_data_oe, .ulpi_dir,
    .ulpi_nxt, .ulpi_stp, .rxcmd_status, .serial_mode_exit, .dplus_pulldown_enable,
    .dminus_pulldown_enable, .func_ctrl, .intf_ctrl, .core_reset, .power_down,
    .fs_preamble_enable, .dplus_pullup, .dminus_pullup, .hs_termination, .dplus_pulldown,
    .dminus_pulldown);

  ufic_link_model link (.clk, .ulpi_dir, .ulpi_nxt, .ulpi_data_out, .ulpi_data_oe,
    .ulpi_data_in, .ulpi_stp);

  // ----------------------------------------------------------------
  // Clock, compare and verdict
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report;
    $display("Counts: checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run is well under a thousand cycles; four thousand means a hang
  initial begin
    #(25 * 4000);
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{'{6'h04, 8'hc5, 6'h04, 8'h45}, '{6'h05, 8'h0a, 6'h05, 8'h4f},
             '{6'h06, 8'h8c, 6'h06, 8'h43}, '{6'h07, 8'hfe, 6'h07, 8'hea},
             '{6'h09, 8'h0f, 6'h08, 8'he0}, '{6'h08, 8'h15, 6'h09, 8'he1},
             '{6'h09, 8'hff, 6'h07, 8'h00}, '{6'h0a, 8'hff, 6'h0a, 8'h00}};
    rst_n = 1'b0;
    rxcmd_status = 8'h5a;
    serial_mode_exit = 1'b0;
    dplus_pulldown_enable = 1'b0;
    dminus_pulldown_enable = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    check8(func_ctrl, 8'h41, "function reset value");
    check8(intf_ctrl, 8'h00, "interface reset value");
    check8({6'h00, ulpi_dir, power_down}, 8'h00, "idle after reset");
    $display("Test reset values done");
    // Plain accesses: write, set or clear, then read back through the same address or a sibling one
    for (int i = 0; i < 8; i++) begin
      link.reg_write(rows[i].waddr, rows[i].wdata, ok);
      link.reg_read(rows[i].raddr, rd, ok2);
      check8({6'h00, ok, ok2}, 8'h03, "bus handshake");
      check8(rd, rows[i].exp, "read back");
    end
    $display("Test register rows done");
    // Every encoding, termination and speed code, pulldown inputs alongside
    for (int i = 0; i < 32; i++) begin
      if (i[4:3] == 2'b11 && i[1:0] != 2'b00) continue;
      v = {3'b010, i[4:0]};
      dplus_pulldown_enable = i[0];
      dminus_pulldown_enable = i[1];
      link.reg_write(6'h04, v, ok);
      @(negedge clk);
      check8({1'b0, ok, fs_preamble_enable, dplus_pullup, dminus_pullup, hs_termination,
              dplus_pulldown, dminus_pulldown},
             {2'b01, i[1:0] == 2'b11, i[2] && i[0] && i[4:3] != 2'b01,
              i[2] && i[1:0] == 2'b10 && i[4:3] != 2'b01, !i[2] && i[1:0] == 2'b00,
              i[0], i[1]}, "speed and termination decode");
    end
    link.reg_write(6'h04, 8'h41, ok);
    $display("Test encoding and speed done");
    // One serial mode only, then the serial logic reports its exit
    link.reg_write(6'h08, 8'h0a, ok);
    @(negedge clk);
    serial_mode_exit = 1'b1;
    @(negedge clk);
    serial_mode_exit = 1'b0;
    @(negedge clk);
    check8(intf_ctrl, 8'h08, "serial exit clears mode bits");
    $display("Test serial exit done");
    // Low power entry by the clear address, exit by stop
    link.reg_write(6'h06, 8'h40, ok);
    repeat (3) @(negedge clk);
    check8({6'h00, ulpi_dir, power_down}, 8'h03, "low power entry");
    link.wake(ok);
    repeat (2) @(negedge clk);
    check8({ok, func_ctrl[6:0]}, 8'hc1, "low power exit restores bit");
    check8({7'h00, power_down}, 8'h00, "powered again");
    $display("Test low power done");
    // Transceiver reset: count core reset cycles, registers must hold meanwhile
    link.reg_write(6'h05, 8'h20, ok);
    @(negedge clk);
    w = 0;
    while (core_reset === 1'b1 && w < 20) begin
      check8({ulpi_dir, func_ctrl[6:0]}, 8'he1, "held during core reset");
      w++;
      @(negedge clk);
    end
    check8(8'(w), {4'h0, ufic_pkg::CORE_RST_CYCLES}, "core reset length");
    check8({ulpi_dir, func_ctrl[6:0]}, 8'h41, "reset bit self clears");
    check8(intf_ctrl, 8'h08, "interface untouched");
    w = 0;
    while (ulpi_data_oe !== 1'b1 && w < 4) begin
      w++;
      @(negedge clk);
    end
    check8(ulpi_data_out, 8'h5a, "status after reset");
    link.reg_read(6'h04, rd, ok);
    check8({ok, rd[6:0]}, 8'hc1, "access after reset");
    $display("Test transceiver reset done");
    // A second reset in mid-run brings both registers back
    link.reg_write(6'h07, 8'he0, ok);
    check8(intf_ctrl, 8'he0, "written before reset");
    rst_n = 1'b0;
    @(negedge clk);
    check8(intf_ctrl, 8'h00, "interface after reset");
    check8(func_ctrl, 8'h41, "function after reset");
    rst_n = 1'b1;
    link.reg_read(6'h07, rd, ok);
    check8({ok, rd[6:0]}, 8'h80, "access after second reset");
    $display("Test second reset done");
    final_report();
  end
endmodule

// *** ufic_ctrl.sv ***
// Function and interface control registers with reset and low-power handshakes
`timescale 1ns/10ps
// Function
// - Clearing low-power bit enters low-power mode
// - Stop exits low-power; bit restored by hardware
// - Reset bit raises direction, resets core
// - After reset: drop direction, clear bit, status
// - Two-bit encoding field selects transmit encoding
// - Termination bit drives pull-up and terminations
// - Speed field enables matching transceiver
// - Speed code three adds full-speed preamble
// - Function register at write, set, clear addresses
// - Interface register at write, set, clear addresses
// - Interface register holds listed controls, reset zero
// - Set ORs data, clear zeroes masked bits
// - Serial mode bits cleared on mode exit
module ufic_ctrl (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           ulpi_data_in,
  output logic      [7:0]           ulpi_data_out,
  output logic                      ulpi_data_oe,
  output logic                      ulpi_dir,
  output logic                      ulpi_nxt,
  input  wire logic                 ulpi_stp,
  input  wire logic [7:0]           rxcmd_status,
  input  wire logic                 serial_mode_exit,
  input  wire logic                 dplus_pulldown_enable,
  input  wire logic                 dminus_pulldown_enable,
  output ufic_pkg::ufic_func_t      func_ctrl,
  output ufic_pkg::ufic_intf_t      intf_ctrl,
  output logic                      core_reset,
  output logic                      power_down,
  output logic                      fs_preamble_enable,
  output logic                      dplus_pullup,
  output logic                      dminus_pullup,
  output logic                      hs_termination,
  output logic                      dplus_pulldown,
  output logic                      dminus_pulldown
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Applies a write, set or clear; reserved bits are masked off
  function automatic logic [7:0] upd(input logic [7:0] cur, input logic [1:0] mode,
                                     input logic [7:0] d, input logic [7:0] msk);
    logic [7:0] v;
    v = cur;
    case (mode)
      ufic_pkg::MODE_WRITE: v = d;
      ufic_pkg::MODE_SET:   v = cur | d;
      ufic_pkg::MODE_CLEAR: v = cur & ~d;
      default:              v = cur;
    endcase
    return v & msk;
  endfunction

  // Read value for an address; unmapped addresses read zero
  function automatic logic [7:0] rd_val(input logic [5:0] a, input logic [7:0] f,
                                        input logic [7:0] i);
    logic [7:0] v;
    v = 8'h00;
    if (a >= ufic_pkg::FUNC_WR_ADDR && a <= ufic_pkg::FUNC_CLR_ADDR) begin
      v = f;
    end else if (a >= ufic_pkg::INTF_WR_ADDR && a <= ufic_pkg::INTF_CLR_ADDR) begin
      v = i;
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ufic_pkg::ufic_state_t state_r;
  ufic_pkg::ufic_func_t  func_r;
  ufic_pkg::ufic_intf_t  intf_r;
  logic [5:0]            addr_r;
  logic [7:0]            wdata_r;
  logic [3:0]            rst_cnt_r;
  logic                  dir_r;
  logic                  nxt_r;
  logic                  oe_r;
  logic [7:0]            dout_r;
  logic                  core_rst_r;
  logic                  commit;
  logic                  rst_done;
  logic                  lpm_exit;
  logic                  fn_hit;
  logic                  if_hit;
  logic [1:0]            fn_mode;
  logic [1:0]            if_mode;

  // Write commit happens when the link stops a write transfer
  assign commit   = (state_r == ufic_pkg::ST_W_DATA) && ulpi_stp;
  assign rst_done = (state_r == ufic_pkg::ST_CORE_RST) && (rst_cnt_r == 4'h0);
  assign lpm_exit = (state_r == ufic_pkg::ST_LPM) && ulpi_stp;

  // Address decode for both registers
  assign fn_hit  = addr_r >= ufic_pkg::FUNC_WR_ADDR && addr_r <= ufic_pkg::FUNC_CLR_ADDR;
  assign if_hit  = addr_r >= ufic_pkg::INTF_WR_ADDR && addr_r <= ufic_pkg::INTF_CLR_ADDR;
  assign fn_mode = 2'(addr_r - ufic_pkg::FUNC_WR_ADDR);
  assign if_mode = 2'(addr_r - ufic_pkg::INTF_WR_ADDR);

  // ---------------------------------------------------------------
  // Bus sequencer
  // ---------------------------------------------------------------
  // Pending reset or suspend outranks new commands, so nothing is taken
  // while the core is being reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ufic_pkg::ST_IDLE;
      addr_r     <= 6'h00;
      wdata_r    <= 8'h00;
      rst_cnt_r  <= 4'h0;
      dir_r      <= 1'b0;
      nxt_r      <= 1'b0;
      oe_r       <= 1'b0;
      dout_r     <= 8'h00;
      core_rst_r <= 1'b0;
    end else begin
      nxt_r <= 1'b0;
      case (state_r)
        ufic_pkg::ST_IDLE: begin
          if (func_r.xcvr_reset) begin
            dir_r      <= 1'b1;
            core_rst_r <= 1'b1;
            rst_cnt_r  <= ufic_pkg::CORE_RST_CYCLES - 4'h1;
            state_r    <= ufic_pkg::ST_CORE_RST;
          end else if (!func_r.low_power_n) begin
            dir_r   <= 1'b1;
            state_r <= ufic_pkg::ST_LPM;
          end else if (ulpi_data_in[7:6] == ufic_pkg::CMD_REG_WRITE) begin
            addr_r  <= ulpi_data_in[5:0];
            nxt_r   <= 1'b1;
            state_r <= ufic_pkg::ST_W_DATA;
          end else if (ulpi_data_in[7:6] == ufic_pkg::CMD_REG_READ) begin
            addr_r  <= ulpi_data_in[5:0];
            nxt_r   <= 1'b1;
            state_r <= ufic_pkg::ST_R_TURN;
          end
        end
        ufic_pkg::ST_W_DATA: begin
          if (ulpi_stp) begin
            state_r <= ufic_pkg::ST_IDLE;
          end else begin
            wdata_r <= ulpi_data_in;
          end
        end
        ufic_pkg::ST_R_TURN: begin
          dir_r   <= 1'b1;
          state_r <= ufic_pkg::ST_R_DATA;
        end
        ufic_pkg::ST_R_DATA: begin
          dout_r  <= rd_val(addr_r, func_r, intf_r);
          oe_r    <= 1'b1;
          state_r <= ufic_pkg::ST_END;
        end
        ufic_pkg::ST_END: begin
          oe_r    <= 1'b0;
          dir_r   <= 1'b0;
          state_r <= ufic_pkg::ST_IDLE;
        end
        ufic_pkg::ST_CORE_RST: begin
          if (rst_cnt_r == 4'h0) begin
            dir_r      <= 1'b0;
            core_rst_r <= 1'b0;
            state_r    <= ufic_pkg::ST_RX_TURN;
          end else begin
            rst_cnt_r <= rst_cnt_r - 4'h1;
          end
        end
        ufic_pkg::ST_RX_TURN: begin
          dir_r   <= 1'b1;
          state_r <= ufic_pkg::ST_RX_DATA;
        end
        ufic_pkg::ST_RX_DATA: begin
          dout_r  <= rxcmd_status;
          oe_r    <= 1'b1;
          state_r <= ufic_pkg::ST_END;
        end
        ufic_pkg::ST_LPM: begin
          if (ulpi_stp) begin
            dir_r   <= 1'b0;
            state_r <= ufic_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= ufic_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Function control register
  // ---------------------------------------------------------------
  // Hardware updates only happen in states where no write can commit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      func_r <= ufic_pkg::FUNC_RESET;
    end else if (commit && fn_hit) begin
      func_r <= upd(func_r, fn_mode, wdata_r, ufic_pkg::FUNC_MASK);
    end else if (rst_done) begin
      func_r.xcvr_reset <= 1'b0;
    end else if (lpm_exit) begin
      func_r.low_power_n <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Interface control register
  // ---------------------------------------------------------------
  // Serial exit is applied after a coincident write: the mode really ended
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intf_r <= ufic_pkg::INTF_RESET;
    end else begin
      if (commit && if_hit) begin
        intf_r <= upd(intf_r, if_mode, wdata_r, ufic_pkg::INTF_MASK);
      end
      if (serial_mode_exit) begin
        intf_r.three_wire_serial_mode <= 1'b0;
        intf_r.six_wire_serial_mode   <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Analog control decode
  // ---------------------------------------------------------------
  // Registered so every analog control leaves the block from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_down         <= 1'b0;
      fs_preamble_enable <= 1'b0;
      dplus_pullup       <= 1'b0;
      dminus_pullup      <= 1'b0;
      hs_termination     <= 1'b0;
      dplus_pulldown     <= 1'b0;
      dminus_pulldown    <= 1'b0;
    end else begin
      power_down <= !func_r.low_power_n;
      fs_preamble_enable <=
        func_r.transceiver_speed_select == ufic_pkg::SPEED_LS_ON_FS;
      dplus_pullup <= func_r.termination_select &&
        func_r.tx_encoding_select != ufic_pkg::ENC_NON_DRIVING &&
        (func_r.transceiver_speed_select == ufic_pkg::SPEED_FULL ||
         func_r.transceiver_speed_select == ufic_pkg::SPEED_LS_ON_FS);
      dminus_pullup <= func_r.termination_select &&
        func_r.tx_encoding_select != ufic_pkg::ENC_NON_DRIVING &&
        func_r.transceiver_speed_select == ufic_pkg::SPEED_LOW;
      hs_termination <= !func_r.termination_select &&
        func_r.transceiver_speed_select == ufic_pkg::SPEED_HIGH;
      dplus_pulldown  <= dplus_pulldown_enable;
      dminus_pulldown <= dminus_pulldown_enable;
    end
  end

  // Encoding, speed and interface controls leave straight from the registers
  assign func_ctrl     = func_r;
  assign intf_ctrl     = intf_r;
  assign ulpi_data_out = dout_r;
  assign ulpi_data_oe  = oe_r;
  assign ulpi_dir      = dir_r;
  assign ulpi_nxt      = nxt_r;
  assign core_reset    = core_rst_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  reset_dir_high_a : assert property (@(posedge clk) disable iff (!rst_n)
    $rose(core_rst_r) |-> dir_r [*4]) else $error("dir low during core reset");

  reset_bit_clear_a : assert property (@(posedge clk) disable iff (!rst_n)
    $rose(core_rst_r) |-> ##4 (!func_r.xcvr_reset && !dir_r))
    else $error("reset bit or dir not cleared after core reset");

  reset_rxcmd_a : assert property (@(posedge clk) disable iff (!rst_n)
    $fell(core_rst_r) |-> ##2 (oe_r && dir_r && dout_r == $past(rxcmd_status)))
    else $error("no rxcmd after core reset");

  reset_no_access_a : assert property (@(posedge clk) disable iff (!rst_n)
    core_rst_r && $past(core_rst_r) |-> $stable(intf_r) && !nxt_r)
    else $error("register access during core reset");

  lpm_enter_a : assert property (@(posedge clk) disable iff (!rst_n)
    $fell(func_r.low_power_n) |-> ##2 (power_down && dir_r))
    else $error("low-power mode not entered");

  lpm_exit_a : assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ufic_pkg::ST_LPM) && ulpi_stp |=> (func_r.low_power_n && !dir_r))
    else $error("low-power exit did not restore bit");

  rsvd_zero_a : assert property (@(posedge clk) disable iff (!rst_n)
    !func_r.rsvd7 && !intf_r.rsvd4 && !intf_r.rsvd2)
    else $error("reserved bit set");

  serial_clear_a : assert property (@(posedge clk) disable iff (!rst_n)
    serial_mode_exit |=> !intf_r.three_wire_serial_mode && !intf_r.six_wire_serial_mode)
    else $error("serial mode bit not cleared on exit");

  set_or_a : assert property (@(posedge clk) disable iff (!rst_n)
    commit && addr_r == ufic_pkg::FUNC_SET_ADDR |=>
      func_r == (($past(func_r) | $past(wdata_r)) & ufic_pkg::FUNC_MASK))
    else $error("set address did not OR data");

  preamble_a : assert property (@(posedge clk) disable iff (!rst_n)
    func_r.transceiver_speed_select == ufic_pkg::SPEED_LS_ON_FS |=> fs_preamble_enable)
    else $error("preamble not enabled for speed code three");

  read_data_a : assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ufic_pkg::ST_R_DATA && addr_r == ufic_pkg::FUNC_CLR_ADDR |=>
      oe_r && dout_r == $past(func_r))
    else $error("function register read mismatch");

endmodule

// *** ufic_link_model.sv ***
// Link controller model that drives register accesses onto the transceiver bus
`timescale 1ns/10ps
module ufic_link_model (
  input  wire logic       clk,
  input  wire logic       ulpi_dir,
  input  wire logic       ulpi_nxt,
  input  wire logic [7:0] ulpi_data_out,
  input  wire logic       ulpi_data_oe,
  output logic      [7:0] ulpi_data_in,
  output logic            ulpi_stp
);
  logic busy;
  logic tgl;

  initial begin
    ulpi_data_in = 8'h00;
    ulpi_stp = 1'b0;
    busy = 1'b0;
    tgl = 1'b0;
  end

  // ----------------------------------------------------------------
  // Idle and released bus
  // ----------------------------------------------------------------
  // While the device owns the bus nothing drives these lines; command-like
  // bytes stand in for them, so a core that took commands then would show it
  always @(negedge clk) begin
    tgl <= ~tgl;
    if (!busy) begin
      ulpi_data_in <= ulpi_dir ? (tgl ? 8'h87 : 8'hc4) : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Bus transfers
  // ----------------------------------------------------------------
  // Command byte; returns in the cycle where the acknowledge should stand
  task automatic send_cmd(input logic [7:0] cmd, output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    busy = 1'b1;
    @(negedge clk);
    while (ulpi_dir && n < 64) begin
      n++;
      @(negedge clk);
    end
    ulpi_data_in <= cmd;
    @(negedge clk);
    ok = (n < 64) && (ulpi_nxt === 1'b1);
  endtask

  // Data byte follows the command, then stop commits it
  task automatic reg_write(input logic [5:0] addr, input logic [7:0] data, output logic ok);
    send_cmd({2'b10, addr}, ok);
    ulpi_data_in <= data;
    @(negedge clk);
    ulpi_data_in <= 8'h00;
    ulpi_stp     <= 1'b1;
    @(negedge clk);
    ulpi_stp <= 1'b0;
    busy = 1'b0;
  endtask

  // Turnaround, one data cycle from the device, turnaround back
  task automatic reg_read(input logic [5:0] addr, output logic [7:0] data, output logic ok);
    send_cmd({2'b11, addr}, ok);
    ulpi_data_in <= 8'h15;
    @(negedge clk);
    ok = ok && (ulpi_dir === 1'b1);
    ulpi_data_in <= 8'h2a;
    @(negedge clk);
    ok = ok && (ulpi_data_oe === 1'b1);
    data = ulpi_data_out;
    ulpi_data_in <= 8'h00;
    @(negedge clk);
    ok = ok && (ulpi_dir === 1'b0);
    busy = 1'b0;
  endtask

  // Stop is held until the device hands the bus back
  task automatic wake(output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    busy = 1'b1;
    @(negedge clk);
    ulpi_stp <= 1'b1;
    while (ulpi_dir && n < 16) begin
      n++;
      @(negedge clk);
    end
    ulpi_stp <= 1'b0;
    ulpi_data_in <= 8'h00;  // Bus pattern must not linger into idle
    ok = (n < 16);
    busy = 1'b0;
  endtask
endmodule

// *** ufic_pkg.sv ***
// Shared constants and carriers for the transceiver function and interface control block
package ufic_pkg;

  // ---------------------------------------------------------------
  // Register addresses (read, write, set, clear)
  // ---------------------------------------------------------------
  localparam logic [5:0] FUNC_WR_ADDR = 6'h04;
  localparam logic [5:0] FUNC_SET_ADDR = 6'h05;
  localparam logic [5:0] FUNC_CLR_ADDR = 6'h06;
  localparam logic [5:0] INTF_WR_ADDR = 6'h07;
  localparam logic [5:0] INTF_SET_ADDR = 6'h08;
  localparam logic [5:0] INTF_CLR_ADDR = 6'h09;

  // ---------------------------------------------------------------
  // Command encodings on the data bus
  // ---------------------------------------------------------------
  localparam logic [1:0] CMD_REG_WRITE = 2'h2;
  localparam logic [1:0] CMD_REG_READ = 2'h3;

  // Write modes handed to the update function
  localparam logic [1:0] MODE_WRITE = 2'h0;
  localparam logic [1:0] MODE_SET = 2'h1;
  localparam logic [1:0] MODE_CLEAR = 2'h2;

  // ---------------------------------------------------------------
  // Reset values and writable-bit masks (reserved bits stay zero)
  // ---------------------------------------------------------------
  localparam logic [7:0] FUNC_RESET = 8'h41;
  localparam logic [7:0] INTF_RESET = 8'h00;
  localparam logic [7:0] FUNC_MASK = 8'h7f;
  localparam logic [7:0] INTF_MASK = 8'heb;

  // Encoding and speed codes
  localparam logic [1:0] ENC_NON_DRIVING = 2'h1;
  localparam logic [1:0] SPEED_HIGH = 2'h0;
  localparam logic [1:0] SPEED_FULL = 2'h1;
  localparam logic [1:0] SPEED_LOW = 2'h2;
  localparam logic [1:0] SPEED_LS_ON_FS = 2'h3;

  // ---------------------------------------------------------------
  // Timing: digital core reset length
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int CORE_RST_NS = 100;
  localparam int CORE_RST_CYCLES_I = (CORE_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CORE_RST_CYCLES = 4'(CORE_RST_CYCLES_I);

  // ---------------------------------------------------------------
  // Register carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       rsvd7;
    logic       low_power_n;
    logic       xcvr_reset;
    logic [1:0] tx_encoding_select;
    logic       termination_select;
    logic [1:0] transceiver_speed_select;
  } ufic_func_t;

  typedef struct packed {
    logic interface_protect_disable;
    logic indicator_pass_through;
    logic indicator_invert;
    logic rsvd4;
    logic clock_power_n;
    logic rsvd2;
    logic three_wire_serial_mode;
    logic six_wire_serial_mode;
  } ufic_intf_t;

  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_W_DATA   = 9'h002,
    ST_R_TURN   = 9'h004,
    ST_R_DATA   = 9'h008,
    ST_END      = 9'h010,
    ST_CORE_RST = 9'h020,
    ST_RX_TURN  = 9'h040,
    ST_RX_DATA  = 9'h080,
    ST_LPM      = 9'h100
  } ufic_state_t;

endpackage
